/* File: rtl/bmf_params.svh */
// constants for the boot mode fallback sequencer
`ifndef BMF_PARAMS_SVH
`define BMF_PARAMS_SVH
`define BMF_CLK_MHZ          25
`define BMF_FLASH_FAST_US    5
`define BMF_FLASH_SLOW_US    300
`define BMF_FLASH_WAIT_US    10
`define BMF_FLASH_WAIT_CYC   (`BMF_FLASH_WAIT_US * `BMF_CLK_MHZ)
`define BMF_SER_TIMEOUT_MS   40
`define BMF_SER_TIMEOUT_CYC  (`BMF_SER_TIMEOUT_MS * 1000 * `BMF_CLK_MHZ)
`define BMF_POLL_DIV         4
`define BMF_SRC_SERIAL_CODE  2'h1
`define BMF_SRC_FLASH_CODE   2'h2
`define BMF_RATE_LO_MHZ      16'h03e8
`define BMF_RATE_HI_MHZ      16'h04b0
`define BMF_MULT_FRAC_BITS   8
`endif

/* File: rtl/bmf_pkg.sv */
// types shared by the boot mode fallback sequencer
package bmf_pkg;
    typedef enum {SRC_NONE, SRC_SERIAL, SRC_FLASH} bmf_src_t;
    typedef enum {ST_STRAP, ST_SELECT, ST_SER_POLL, ST_FL_RST, ST_FL_WAIT,
                  ST_LOAD, ST_DONE} bmf_state_t;
endpackage

/* File: rtl/bmf_stream_if.sv */
// valid/ready word stream between the sequencer and its buffer
`timescale 1ns/1ps
interface bmf_stream_if #(parameter int DW = 8);
    logic          valid;
    logic          ready;
    logic [DW-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: rtl/bmf_pair_buf.sv */
// two-entry buffer, output word and ready held in flip-flops
`timescale 1ns/1ps
module bmf_pair_buf #(
    parameter int DW = 8
) (
    input  wire logic  ref_clk,
    input  wire logic  rst,
    bmf_stream_if.snk  inPort,
    bmf_stream_if.src  outPort
);
    logic [DW-1:0] headReg, headNext, tailReg, tailNext;
    logic [1:0]    countReg, countNext;
    logic          validReg, validNext, readyReg, readyNext;
    logic          push, pop;

    // a word must be at least one bit wide
    if (DW < 1)
        $error("bmf_pair_buf: data width must be positive");

    // next state of both entries
    always_comb
    begin
        push      = inPort.valid & readyReg;
        pop       = validReg & outPort.ready;
        headNext  = headReg;
        tailNext  = tailReg;
        countNext = 2'(countReg + {1'b0, push} - {1'b0, pop});
        if (pop)
        begin
            headNext = (countReg == 2'h2) ? tailReg : inPort.data;
        end
        else if (push && countReg == 2'h0)
        begin
            headNext = inPort.data;
        end
        if (push && ((countReg == 2'h1 && !pop) || countReg == 2'h2))
        begin
            tailNext = inPort.data;
        end
        validNext = (countNext != 2'h0);
        readyNext = (countNext != 2'h2);
    end

    // registers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            headReg  <= '0;
            tailReg  <= '0;
            countReg <= 2'h0;
            validReg <= 1'b0;
            readyReg <= 1'b1;
        end
        else
        begin
            headReg  <= headNext;
            tailReg  <= tailNext;
            countReg <= countNext;
            validReg <= validNext;
            readyReg <= readyNext;
        end
    end

    assign inPort.ready  = readyReg;
    assign outPort.valid = validReg;
    assign outPort.data  = headReg;
endmodule // bmf_pair_buf

/* File: rtl/bmf_boot_sequencer.sv */
// boot source fallback sequencer with serial polling and flash reset wait
`timescale 1ns/1ps
`include "bmf_params.svh"
module bmf_boot_sequencer import bmf_pkg::*; #(
    parameter int SER_TIMEOUT_CYC = `BMF_SER_TIMEOUT_CYC,
    parameter int FLASH_WAIT_CYC  = `BMF_FLASH_WAIT_CYC,
    parameter int POLL_DIV        = `BMF_POLL_DIV
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        strapAppMaster,
    input  wire logic [1:0]  strapPrimary,
    input  wire logic [1:0]  strapSecondary,
    input  wire logic [2:0]  strapClkSel,
    input  wire logic        fuseHighRate,
    input  wire logic        rxValid,
    input  wire logic [7:0]  rxData,
    input  wire logic        rxLast,
    input  wire logic        flashReady,
    input  wire logic        flashRdValid,
    input  wire logic [7:0]  flashRdData,
    input  wire logic        flashRdLast,
    input  wire logic        loadReady,
    output logic             rxPoll,
    output logic             flashRstCmd,
    output logic             flashRdReq,
    output logic             loadValid,
    output logic [7:0]       loadData,
    output logic             bootDone,
    output logic             flashUnresponsive,
    output logic [1:0]       activeSource,
    output logic [7:0]       attemptCount,
    output logic [15:0]      pllMult
);
    // refuse parameters the counters cannot serve
    if (POLL_DIV < 2 || POLL_DIV > 256 || SER_TIMEOUT_CYC < 1
        || FLASH_WAIT_CYC < 1)
        $error("bmf_boot_sequencer: unusable timing parameters");

    // reset completion at 5 us fits, first reset at 300 us does not
    localparam int FAST_CYC = `BMF_FLASH_FAST_US * `BMF_CLK_MHZ;
    localparam int SLOW_CYC = `BMF_FLASH_SLOW_US * `BMF_CLK_MHZ;
    if (FLASH_WAIT_CYC < FAST_CYC || FLASH_WAIT_CYC >= SLOW_CYC)
        $error("bmf_boot_sequencer: flash wait out of range");

    // strap code to boot source
    function automatic bmf_src_t decodeSrc(input logic [1:0] code);
        unique case (code)
            `BMF_SRC_SERIAL_CODE: decodeSrc = SRC_SERIAL;
            `BMF_SRC_FLASH_CODE:  decodeSrc = SRC_FLASH;
            default:              decodeSrc = SRC_NONE;
        endcase
    endfunction

    // source code shown on the status output
    function automatic logic [1:0] srcCode(input bmf_src_t src);
        unique case (src)
            SRC_SERIAL: srcCode = `BMF_SRC_SERIAL_CODE;
            SRC_FLASH:  srcCode = `BMF_SRC_FLASH_CODE;
            SRC_NONE:   srcCode = 2'h0;
        endcase
    endfunction

    // indicated input clock in units of 10 kHz
    function automatic logic [15:0] clkX100(input logic [2:0] sel);
        unique case (sel)
            3'h0: clkX100 = 16'h1388;    // 50.00
            3'h1: clkX100 = 16'h1a0b;    // 66.67
            3'h2: clkX100 = 16'h1f40;    // 80.00
            3'h3: clkX100 = 16'h2710;    // 100.00
            3'h4: clkX100 = 16'h3d09;    // 156.25
            3'h5: clkX100 = 16'h61a8;    // 250.00
            3'h6: clkX100 = 16'h7a12;    // 312.50
            3'h7: clkX100 = 16'h3000;    // 122.88
        endcase
    endfunction

    bmf_stream_if #(.DW(8)) bufIn ();
    bmf_stream_if #(.DW(8)) bufOut ();

    bmf_pair_buf #(.DW(8)) uBuf (
        .ref_clk (ref_clk),
        .rst     (rst),
        .inPort  (bufIn.snk),
        .outPort (bufOut.src)
    );

    // poll rate divider, one-cycle enable pulse
    logic [7:0] divReg, divNext;
    logic       tickReg, tickNext;
    always_comb
    begin
        tickNext = (divReg == 8'(POLL_DIV - 1));
        divNext  = tickNext ? 8'h00 : 8'(divReg + 8'h01);
    end
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            divReg  <= 8'h00;
            tickReg <= 1'b0;
        end
        else
        begin
            divReg  <= divNext;
            tickReg <= tickNext;
        end
    end

    bmf_state_t  stateReg, stateNext;
    bmf_src_t    priReg, priNext, secReg, secNext, srcReg, srcNext;
    logic        masterReg, masterNext, secSelReg, secSelNext;
    logic [31:0] timerReg, timerNext;
    logic [7:0]  attemptsReg, attemptsNext;
    logic [15:0] multReg, multNext;
    logic [1:0]  codeReg, codeNext;
    logic        pollReg, pollNext, rstCmdReg, rstCmdNext;
    logic        rdReg, rdNext, unrespReg, unrespNext, doneReg, doneNext;
    logic        taken, lastTaken, issue, fail;
    logic [31:0] multWide;
    bmf_src_t    curSrc;

    // words taken from whichever source is strobed this cycle
    assign taken     = (pollReg & rxValid) | (rdReg & flashRdValid);
    assign lastTaken = (pollReg & rxValid & rxLast)
                     | (rdReg & flashRdValid & flashRdLast);
    assign bufIn.valid = taken;
    assign bufIn.data  = rdReg ? flashRdData : rxData;
    assign bufOut.ready = loadReady;

    // sequencer next state
    always_comb
    begin
        stateNext    = stateReg;
        priNext      = priReg;
        secNext      = secReg;
        srcNext      = srcReg;
        masterNext   = masterReg;
        secSelNext   = secSelReg;
        timerNext    = timerReg;
        attemptsNext = attemptsReg;
        multNext     = multReg;
        pollNext     = 1'b0;
        rstCmdNext   = 1'b0;
        rdNext       = 1'b0;
        unrespNext   = 1'b0;
        doneNext     = doneReg;
        fail         = 1'b0;
        multWide     = '0;
        curSrc       = secSelReg ? secReg : priReg;
        issue        = tickReg & bufIn.ready & !pollReg & !rdReg;
        unique case (stateReg)
            ST_STRAP:
            begin
                masterNext = strapAppMaster;
                priNext    = decodeSrc(strapPrimary);
                secNext    = strapAppMaster ? decodeSrc(strapSecondary)
                                            : decodeSrc(strapPrimary);
                multWide   = (32'(fuseHighRate ? `BMF_RATE_HI_MHZ
                                               : `BMF_RATE_LO_MHZ)
                              * 32'd100 << `BMF_MULT_FRAC_BITS)
                             / 32'(clkX100(strapClkSel));
                multNext   = multWide[15:0];
                secSelNext = 1'b0;
                stateNext  = ST_SELECT;
            end
            ST_SELECT:
            begin
                srcNext   = curSrc;
                timerNext = '0;
                if (curSrc == SRC_SERIAL)
                    stateNext = ST_SER_POLL;
                else if (curSrc == SRC_FLASH && masterReg)
                    stateNext = ST_FL_RST;
                else
                    fail = 1'b1;
            end
            ST_SER_POLL:
            begin
                pollNext  = issue;
                timerNext = timerReg + 32'h1;
                if (taken)
                    stateNext = lastTaken ? ST_DONE : ST_LOAD;
                else if (timerReg >= 32'(SER_TIMEOUT_CYC - 1))
                    fail = 1'b1;
            end
            ST_FL_RST:
            begin
                rstCmdNext = 1'b1;
                stateNext  = ST_FL_WAIT;
            end
            ST_FL_WAIT:
            begin
                timerNext = timerReg + 32'h1;
                if (flashReady && !rstCmdReg)
                    stateNext = ST_LOAD;
                else if (timerReg >= 32'(FLASH_WAIT_CYC - 1))
                begin
                    unrespNext = 1'b1;
                    fail       = 1'b1;
                end
            end
            ST_LOAD:
            begin
                pollNext = issue & (srcReg == SRC_SERIAL);
                rdNext   = issue & (srcReg == SRC_FLASH);
                if (lastTaken)
                    stateNext = ST_DONE;
            end
            ST_DONE:
            begin
                doneNext = !bufOut.valid & !taken;
            end
        endcase
        if (fail)
        begin
            secSelNext   = !secSelReg;
            attemptsNext = 8'(attemptsReg + 8'h01);
            pollNext     = 1'b0; // no poll outlives a failed attempt
            stateNext    = ST_SELECT;
        end
        codeNext = srcCode(srcNext);
    end

    // sequencer registers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            stateReg    <= ST_STRAP;
            priReg      <= SRC_NONE;
            secReg      <= SRC_NONE;
            srcReg      <= SRC_NONE;
            masterReg   <= 1'b0;
            secSelReg   <= 1'b0;
            timerReg    <= '0;
            attemptsReg <= 8'h00;
            multReg     <= 16'h0000;
            pollReg     <= 1'b0;
            rstCmdReg   <= 1'b0;
            rdReg       <= 1'b0;
            unrespReg   <= 1'b0;
            doneReg     <= 1'b0;
            codeReg     <= 2'h0;
        end
        else
        begin
            stateReg    <= stateNext;
            priReg      <= priNext;
            secReg      <= secNext;
            srcReg      <= srcNext;
            masterReg   <= masterNext;
            secSelReg   <= secSelNext;
            timerReg    <= timerNext;
            attemptsReg <= attemptsNext;
            multReg     <= multNext;
            pollReg     <= pollNext;
            rstCmdReg   <= rstCmdNext;
            rdReg       <= rdNext;
            unrespReg   <= unrespNext;
            doneReg     <= doneNext;
            codeReg     <= codeNext;
        end
    end

    // outputs straight from flip-flops
    assign rxPoll            = pollReg;
    assign flashRstCmd       = rstCmdReg;
    assign flashRdReq        = rdReg;
    assign loadValid         = bufOut.valid;
    assign loadData          = bufOut.data;
    assign bootDone          = doneReg;
    assign flashUnresponsive = unrespReg;
    assign activeSource      = codeReg;
    assign attemptCount      = attemptsReg;
    assign pllMult           = multReg;
endmodule // bmf_boot_sequencer

/* File: verif/bmf_boot_asserts.sv */
// port checker for the boot sequencer
`timescale 1ns/1ps
module bmf_boot_asserts #(
    parameter int FLASH_WAIT_CYC = 250
) (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        strapAppMaster,
    input wire logic        loadReady,
    input wire logic        rxPoll,
    input wire logic        flashRstCmd,
    input wire logic        loadValid,
    input wire logic [7:0]  loadData,
    input wire logic        bootDone,
    input wire logic        flashUnresponsive,
    input wire logic [7:0]  attemptCount,
    input wire logic [15:0] pllMult
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    int waitCnt;
    // cycles since the last flash reset command
    always_ff @(posedge ref_clk) waitCnt <= flashRstCmd ? 0 : waitCnt + 1;
    property p_gap; rxPoll |=> !rxPoll [*3]; endproperty
    a_gap: assert property (p_gap) else $error("polls too close");
    property p_cmd; flashRstCmd |=> !flashRstCmd; endproperty
    a_cmd: assert property (p_cmd) else $error("long reset cmd");
    property p_mst; flashRstCmd |-> strapAppMaster; endproperty
    a_mst: assert property (p_mst) else $error("flash not master");
    property p_unr;
        flashUnresponsive |-> waitCnt > FLASH_WAIT_CYC - 5
            && waitCnt < FLASH_WAIT_CYC + 6;
    endproperty
    a_unr: assert property (p_unr) else $error("wait length");
    property p_hold;
        loadValid && !loadReady |=> loadValid && $stable(loadData);
    endproperty
    a_hold: assert property (p_hold) else $error("word dropped");
    property p_keep;
        bootDone |=> bootDone && !rxPoll && !flashRstCmd;
    endproperty
    a_keep: assert property (p_keep) else $error("done not final");
    property p_step;
        attemptCount != $past(attemptCount)
            |-> attemptCount == $past(attemptCount) + 8'h01;
    endproperty
    a_step: assert property (p_step) else $error("attempt step");
    property p_pll;
        !$past(rst) && !$past(rst, 2) |-> $stable(pllMult);
    endproperty
    a_pll: assert property (p_pll) else $error("pll moved");
    c_done: cover property ($rose(bootDone));
    c_unr: cover property (flashUnresponsive);
    c_stall: cover property (loadValid && !loadReady [*2]);
endmodule // bmf_boot_asserts

bind bmf_boot_sequencer bmf_boot_asserts #(.FLASH_WAIT_CYC(FLASH_WAIT_CYC))
    u_bmf_boot_asserts (.ref_clk, .rst, .strapAppMaster, .loadReady, .rxPoll,
    .flashRstCmd, .loadValid, .loadData, .bootDone, .flashUnresponsive,
    .attemptCount, .pllMult);

/* File: verif/bmf_boot_partner.sv */
// far-side model: serial boot host and flash device
`timescale 1ns/1ps
module bmf_boot_partner #(
    parameter int LEN  = 4,
    parameter int SLOW = 7500,
    parameter int FAST = 125
) (
    input  wire logic  ref_clk,
    input  wire logic  rst,
    input  wire logic  pwrUp,
    input  wire logic  hostEn,
    input  wire logic  rxPoll,
    input  wire logic  flashRstCmd,
    input  wire logic  flashRdReq,
    output logic       rxValid,
    output logic [7:0] rxData,
    output logic       rxLast,
    output logic       flashReady,
    output logic       flashRdValid,
    output logic [7:0] flashRdData,
    output logic       flashRdLast
);
    logic [7:0] sIdx;
    logic [7:0] fIdx;
    logic       warm;
    logic       armed;
    int         busy;
    // answers only inside a strobe cycle; data lines wander elsewhere
    assign rxValid = rxPoll && hostEn && sIdx < LEN;
    assign rxData = rxPoll ? 8'ha0 + sIdx : ~sIdx;
    assign rxLast = sIdx == LEN - 1;
    assign flashReady = armed && busy == 0;
    assign flashRdValid = flashRdReq && flashReady && fIdx < LEN;
    assign flashRdData = flashRdReq ? 8'h50 + fIdx : ~fIdx;
    assign flashRdLast = fIdx == LEN - 1;
    // flash state survives device reset, only power-up clears it
    always @(posedge ref_clk)
    begin
        if (rst) sIdx <= 8'h00;
        else if (rxValid) sIdx <= sIdx + 8'h01;
        if (pwrUp)
        begin
            warm <= 1'b0;
            armed <= 1'b0;
        end
        else if (flashRstCmd)
        begin
            busy <= warm ? FAST : SLOW;
            warm <= 1'b1;
            armed <= 1'b1;
            fIdx <= 8'h00;
        end
        else if (busy > 0) busy <= busy - 1;
        else if (flashRdValid) fIdx <= fIdx + 8'h01;
    end
endmodule // bmf_boot_partner

/* File: verif/tb_top.sv */
// self-checking bench for the boot sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        pwrUp = 1'b1;
    logic        hostEn = 1'b0;
    logic        loadReady = 1'b1;
    logic        appM = 1'b1;
    logic [1:0]  prim = 2'h1;
    logic [1:0]  sec = 2'h2;
    logic [2:0]  clkSel = 3'h0;
    logic        fuseHi = 1'b0;
    logic        rxValid, rxLast, flashReady, flashRdValid, flashRdLast;
    logic [7:0]  rxData, flashRdData, loadData, attemptCount;
    logic        rxPoll, flashRstCmd, flashRdReq, loadValid, bootDone;
    logic        flashUnresponsive;
    logic [1:0]  activeSource;
    logic [15:0] pllMult;
    logic [7:0]  got[$];
    int          n_fail = 0, comparisons = 0, cyc = 0;
    int          nCmd = 0, nUnr = 0, nPoll = 0, nRd = 0;
    bmf_boot_sequencer #(.SER_TIMEOUT_CYC(50)) u_bmf_boot_sequencer (
        .ref_clk, .rst, .strapAppMaster(appM), .strapPrimary(prim),
        .strapSecondary(sec), .strapClkSel(clkSel), .fuseHighRate(fuseHi),
        .rxValid, .rxData, .rxLast, .flashReady, .flashRdValid, .flashRdData,
        .flashRdLast, .loadReady, .rxPoll, .flashRstCmd, .flashRdReq,
        .loadValid, .loadData, .bootDone, .flashUnresponsive, .activeSource,
        .attemptCount, .pllMult);
    bmf_boot_partner u_bmf_boot_partner (.ref_clk, .rst, .pwrUp, .hostEn,
        .rxPoll, .flashRstCmd, .flashRdReq, .rxValid, .rxData, .rxLast,
        .flashReady, .flashRdValid, .flashRdData, .flashRdLast);
    initial forever #20 ref_clk = ~ref_clk;
    // watchdog, event counts and capture of the load stream
    always @(posedge ref_clk)
    begin
        cyc++;
        if (loadValid && loadReady) got.push_back(loadData);
        if (flashRstCmd) nCmd++;
        if (flashUnresponsive) nUnr++;
        if (rxPoll) nPoll++;
        if (flashRdReq) nRd++;
        if (cyc == 20000)
        begin
            n_fail++;
            summarize();
        end
    end
    task automatic summarize();
        if (n_fail == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic straps(logic m, logic [1:0] p, s, logic [2:0] c, logic f);
        appM <= m;
        prim <= p;
        sec <= s;
        clkSel <= c;
        fuseHi <= f;
    endtask
    // two-cycle device reset, optional flash power cycle
    task automatic dev_reset(logic pwr);
        @(posedge ref_clk);
        rst <= 1'b1;
        pwrUp <= pwr;
        @(posedge ref_clk);
        pwrUp <= 1'b0;
        @(posedge ref_clk);
        rst <= 1'b0;
        got.delete();
        nCmd = 0;
        nUnr = 0;
        nPoll = 0;
        nRd = 0;
    endtask
    task automatic wait_done(int lim);
        for (int i = 0; i < lim && bootDone !== 1'b1; i++) @(posedge ref_clk);
        @(posedge ref_clk);
        `CHK(bootDone, 1'b1)
    endtask
    task automatic chk_img(logic [7:0] base);
        `CHK(got.size(), 4)
        foreach (got[i]) `CHK(got[i], base + 8'(i))
    endtask
    // serial primary answers while the sink stalls
    task automatic t_serial();
        straps(1'b1, 2'h1, 2'h2, 3'h3, 1'b0);
        hostEn <= 1'b1;
        loadReady <= 1'b0;
        dev_reset(1'b1);
        repeat (40) @(posedge ref_clk);
        `CHK(loadValid, 1'b1)
        loadReady <= 1'b1;
        wait_done(500);
        chk_img(8'ha0);
        `CHK(attemptCount, 8'h00)
        `CHK(activeSource, 2'h1)
        `CHK(nCmd, 0)
        `CHK(nPoll, 4)
        `CHK(pllMult, 16'h0a00)
    endtask
    // silent host, cold flash: serial, flash, serial, flash again
    task automatic t_fallback();
        straps(1'b1, 2'h1, 2'h2, 3'h3, 1'b1);
        hostEn <= 1'b0;
        dev_reset(1'b1);
        wait_done(3000);
        chk_img(8'h50);
        `CHK(attemptCount, 8'h03)
        `CHK(nUnr, 1)
        `CHK(nCmd, 2)
        `CHK(nRd, 4)
        `CHK(activeSource, 2'h2)
        `CHK(pllMult, 16'h0c00)
    endtask
    // not master: neither flash nor the serial secondary is tried
    task automatic t_slave();
        straps(1'b0, 2'h2, 2'h1, 3'h0, 1'b0);
        hostEn <= 1'b1;
        dev_reset(1'b0);
        repeat (60) @(posedge ref_clk);
        `CHK(nCmd, 0)
        `CHK(nPoll, 0)
        `CHK(bootDone, 1'b0)
        `CHK(attemptCount != 8'h00, 1'b1)
        `CHK(pllMult, 16'h1400)
    endtask
    // flash primary fails cold; board re-resets with flash powered
    task automatic t_rereset();
        straps(1'b1, 2'h2, 2'h1, 3'h5, 1'b0);
        hostEn <= 1'b0;
        dev_reset(1'b1);
        for (int i = 0; i < 20 && nCmd == 0; i++) @(posedge ref_clk);
        `CHK(nPoll, 0)
        for (int i = 0; i < 400 && nUnr == 0; i++) @(posedge ref_clk);
        `CHK(nUnr, 1)
        dev_reset(1'b0);
        wait_done(600);
        chk_img(8'h50);
        `CHK(attemptCount, 8'h00)
        `CHK(pllMult, 16'h0400)
    endtask
    initial
    begin
        t_serial();
        t_fallback();
        t_slave();
        t_rereset();
        summarize();
    end
endmodule // tb_top
